//--- bsi_flags.sv
// Sticky write-one-to-clear event flags
`timescale 1ns/100ps
`default_nettype none
module bsi_flags
  import bsi_pkg::*;
#(
  parameter int unsigned N = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] flags
);

  typedef struct packed {
    logic [N-1:0] flag;
  } bsi_flags_state_t;

  bsi_flags_state_t s_reg;
  bsi_flags_state_t s_next;
  logic [N-1:0] flag_next;

  generate
    if (N < 1 || N > 4) begin : g_bad_n
      $error("bsi_flags: N out of range");
    end
  endgenerate

  // ************************************************************
  // Per-flag update
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      assign flag_next[i] = set[i] | (s_reg.flag[i] & ~clr[i]);
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.flag = flag_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.flag <= RST_FLAGS[N-1:0];
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags = s_reg.flag;

endmodule
`default_nettype wire

//--- bsi_pkg.sv
// Package: register map, field positions, reset values and shared types
package bsi_pkg;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [11:0] IDX_STATUS_LATCHED = 12'h06E;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h070;
  localparam logic [11:0] IDX_COUNT_LOW = 12'h074;
  localparam logic [11:0] IDX_COUNT_HIGH = 12'h076;
  localparam logic [11:0] IDX_LIVE_STATUS = 12'h0F0;
  localparam logic [11:0] IDX_CONTROL = 12'h0F2;

  localparam logic [15:0] ADDR_STATUS_LATCHED = {2'b00, IDX_STATUS_LATCHED, 2'b00};
  localparam logic [15:0] ADDR_IRQ_ENABLE = {2'b00, IDX_IRQ_ENABLE, 2'b00};
  localparam logic [15:0] ADDR_COUNT_LOW = {2'b00, IDX_COUNT_LOW, 2'b00};
  localparam logic [15:0] ADDR_COUNT_HIGH = {2'b00, IDX_COUNT_HIGH, 2'b00};
  localparam logic [15:0] ADDR_LIVE_STATUS = {2'b00, IDX_LIVE_STATUS, 2'b00};
  localparam logic [15:0] ADDR_CONTROL = {2'b00, IDX_CONTROL, 2'b00};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned BIT_UPDATE_DONE = 3;
  localparam int unsigned BIT_ERROR_SEEN = 2;
  localparam int unsigned BIT_COUNT_NONZERO = 1;
  localparam int unsigned BIT_SYNC = 0;
  localparam int unsigned CTL_UPDATE_REQ = 0;
  localparam int unsigned CTL_GLOBAL_IRQ_EN = 1;
  localparam int unsigned COUNT_LOW_W = 16;
  localparam int unsigned TALLY_W_DEF = 24;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] RST_IRQ_EN = 4'h0;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [31:0] RST_TALLY = 32'h0000_0000;
  localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

  // ************************************************************
  // Shared types
  // ************************************************************
  typedef struct packed {
    logic update_done;
    logic error_seen;
    logic count_nonzero;
    logic sync_change;
  } bsi_events_t;

endpackage

//--- bsi_tally.sv
// Saturating error accumulator with snapshot on counter update
`timescale 1ns/100ps
`default_nettype none
module bsi_tally
  import bsi_pkg::*;
#(
  parameter int unsigned WIDTH = TALLY_W_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic count_en,
  input wire logic update,
  output logic [WIDTH-1:0] error_tally,
  output logic count_nonzero
);

  typedef struct packed {
    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] snap;
    logic nonzero;
  } bsi_tally_state_t;

  localparam logic [WIDTH-1:0] TALLY_MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] TALLY_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  bsi_tally_state_t s_reg;
  bsi_tally_state_t s_next;

  generate
    if (WIDTH <= COUNT_LOW_W || WIDTH > 32) begin : g_bad_w
      $error("bsi_tally: WIDTH must be 17 to 32");
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    if (update) begin
      s_next.snap = s_reg.acc;
      s_next.acc = count_en ? TALLY_ONE : '0;
    end else if (count_en && s_reg.acc != TALLY_MAX) begin
      s_next.acc = s_reg.acc + TALLY_ONE;
    end
    s_next.nonzero = (s_next.acc != '0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.acc <= RST_TALLY[WIDTH-1:0];
      s_reg.snap <= RST_TALLY[WIDTH-1:0];
      s_reg.nonzero <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign error_tally = s_reg.snap;
  assign count_nonzero = s_reg.nonzero;

endmodule
`default_nettype wire

//--- bsi_top.sv
// Bit error tester status latches, interrupt enables and error count registers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module bsi_top
  import bsi_pkg::*;
#(
  parameter int unsigned TALLY_W = TALLY_W_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_error,
  input wire logic pattern_unlocked,
  output logic irq,
  output logic update_done_live,
  output logic count_nonzero_live,
  output logic sync_lost_live
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] irq_en;
    logic update_req;
    logic global_en;
    logic update_req_prev;
    logic update_done_live;
    logic update_done_prev;
    logic nonzero_prev;
    logic sync_lost_live;
    logic sync_prev;
  } bsi_top_state_t;

  bsi_top_state_t s_reg;
  bsi_top_state_t s_next;

  bsi_events_t events;
  logic [3:0] flags;
  logic [3:0] flag_clr;
  logic [3:0] irq_gate;
  logic [TALLY_W-1:0] error_tally;
  logic tally_nonzero;
  logic update_pulse;
  logic count_en;
  logic acc_phase;
  logic wr_take;
  logic addr_hit;
  logic [31:0] rd_value;

  generate
    if (TALLY_W <= COUNT_LOW_W || TALLY_W > 32) begin : g_bad_w
      $error("bsi_top: TALLY_W must be 17 to 32");
    end
  endgenerate

  // ************************************************************
  // APB decode
  // ************************************************************
  assign acc_phase = psel & penable & ~s_reg.pready;
  assign wr_take = psel & penable & s_reg.pready & pwrite & ~s_reg.pslverr;

  always_comb begin
    rd_value = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      ADDR_STATUS_LATCHED: begin
        rd_value[3:0] = flags;
      end
      ADDR_IRQ_ENABLE: begin
        rd_value[3:0] = s_reg.irq_en;
      end
      ADDR_COUNT_LOW: begin
        rd_value[COUNT_LOW_W-1:0] = error_tally[COUNT_LOW_W-1:0];
      end
      ADDR_COUNT_HIGH: begin
        rd_value[TALLY_W-COUNT_LOW_W-1:0] = error_tally[TALLY_W-1:COUNT_LOW_W];
      end
      ADDR_LIVE_STATUS: begin
        rd_value[BIT_UPDATE_DONE] = s_reg.update_done_live;
        rd_value[BIT_COUNT_NONZERO] = tally_nonzero;
        rd_value[BIT_SYNC] = s_reg.sync_lost_live;
      end
      ADDR_CONTROL: begin
        rd_value[CTL_UPDATE_REQ] = s_reg.update_req;
        rd_value[CTL_GLOBAL_IRQ_EN] = s_reg.global_en;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  assign flag_clr = (wr_take && paddr == ADDR_STATUS_LATCHED) ? pwdata[3:0] : 4'h0;

  // ************************************************************
  // Events
  // ************************************************************
  assign update_pulse = s_reg.update_req & ~s_reg.update_req_prev;
  assign count_en = bit_error & ~pattern_unlocked;

  always_comb begin
    events.update_done = s_reg.update_done_live & ~s_reg.update_done_prev;
    events.error_seen = bit_error;
    events.count_nonzero = tally_nonzero & ~s_reg.nonzero_prev;
    events.sync_change = s_reg.sync_lost_live ^ s_reg.sync_prev;
  end

  // ************************************************************
  // Interrupt gating
  // ************************************************************
  always_comb begin
    irq_gate[BIT_UPDATE_DONE] = s_reg.irq_en[BIT_UPDATE_DONE];
    irq_gate[BIT_ERROR_SEEN] = s_reg.irq_en[BIT_ERROR_SEEN] & s_reg.global_en;
    irq_gate[BIT_COUNT_NONZERO] = s_reg.irq_en[BIT_COUNT_NONZERO] & s_reg.global_en;
    irq_gate[BIT_SYNC] = s_reg.irq_en[BIT_SYNC] & s_reg.global_en;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.pready = acc_phase;
    s_next.pslverr = acc_phase & ~addr_hit;
    s_next.prdata = (acc_phase && !pwrite && addr_hit) ? rd_value : RST_PRDATA;
    if (wr_take && paddr == ADDR_IRQ_ENABLE) begin
      s_next.irq_en = pwdata[3:0];
    end
    if (wr_take && paddr == ADDR_CONTROL) begin
      s_next.update_req = pwdata[CTL_UPDATE_REQ];
      s_next.global_en = pwdata[CTL_GLOBAL_IRQ_EN];
    end
    s_next.update_req_prev = s_reg.update_req;
    s_next.update_done_live = s_reg.update_req & (s_reg.update_done_live | update_pulse);
    s_next.update_done_prev = s_reg.update_done_live;
    s_next.nonzero_prev = tally_nonzero;
    s_next.sync_lost_live = pattern_unlocked;
    s_next.sync_prev = s_reg.sync_lost_live;
    s_next.irq = |(flags & irq_gate);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.prdata <= RST_PRDATA;
      s_reg.pready <= 1'b0;
      s_reg.pslverr <= 1'b0;
      s_reg.irq <= 1'b0;
      s_reg.irq_en <= RST_IRQ_EN;
      s_reg.update_req <= 1'b0;
      s_reg.global_en <= 1'b0;
      s_reg.update_req_prev <= 1'b0;
      s_reg.update_done_live <= 1'b0;
      s_reg.update_done_prev <= 1'b0;
      s_reg.nonzero_prev <= 1'b0;
      s_reg.sync_lost_live <= 1'b0;
      s_reg.sync_prev <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Submodules
  // ************************************************************
  bsi_flags #(
    .N(4)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(events),
    .clr(flag_clr),
    .flags(flags)
  );

  bsi_tally #(
    .WIDTH(TALLY_W)
  ) u_tally (
    .pclk(pclk),
    .presetn(presetn),
    .count_en(count_en),
    .update(update_pulse),
    .error_tally(error_tally),
    .count_nonzero(tally_nonzero)
  );

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq = s_reg.irq;
  assign update_done_live = s_reg.update_done_live;
  assign count_nonzero_live = tally_nonzero;
  assign sync_lost_live = s_reg.sync_lost_live;

endmodule
`default_nettype wire

//--- bsi_top_assertions.sv
// Port checker for the status and error count block
`timescale 1ns/100ps
`default_nettype none
module bsi_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_error,
  input wire logic pattern_unlocked,
  input wire logic irq,
  input wire logic update_done_live,
  input wire logic count_nonzero_live,
  input wire logic sync_lost_live
);
  // ******************
  // Properties
  // ******************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic wdone = psel && pwrite && pready;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  apb_wait_a: assert property (setup_s ##1 access_s |=> pready)
    else $error("pready late");
  err_resp_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  sync_follow_a: assert property (1'b1 |=> sync_lost_live == $past(pattern_unlocked))
    else $error("sync live wrong");
  nz_set_a: assert property (bit_error && !pattern_unlocked |-> ##[1:2] count_nonzero_live)
    else $error("nonzero live missing");
  nz_hold_a: assert property (pattern_unlocked [*3] ##0 !count_nonzero_live |=> !count_nonzero_live)
    else $error("counted while unlocked");
  nz_fall_a: assert property ($fell(count_nonzero_live) |-> $past(wdone, 2) || $past(wdone, 3))
    else $error("nonzero fell without update");
  upd_live_a: assert property ($changed(update_done_live) |-> $past(wdone, 2))
    else $error("update live moved alone");
  irq_fall_a: assert property ($fell(irq) |-> $past(wdone, 2))
    else $error("irq fell without write");
endmodule
bind bsi_top bsi_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .bit_error(bit_error), .pattern_unlocked(pattern_unlocked), .irq(irq),
  .update_done_live(update_done_live), .count_nonzero_live(count_nonzero_live),
  .sync_lost_live(sync_lost_live));
`default_nettype wire

//--- bsi_top_tb.sv
// Directed bench for the status and error count block
`timescale 1ns/100ps
`default_nettype none
module bsi_top_tb
  import bsi_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic bit_error = 1'b0;
  logic pattern_unlocked = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, upd_live, nz_live, sync_live, rerr;
  int errors = 0;
  int checked = 0;
  always #20 pclk = ~pclk;
  bsi_top u_bsi_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_error(bit_error), .pattern_unlocked(pattern_unlocked),
    .irq(irq), .update_done_live(upd_live), .count_nonzero_live(nz_live),
    .sync_lost_live(sync_live));
  // ******************
  // Tasks
  // ******************
  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16) begin
      errors++;
      test_done();
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdat, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic errs(input int n);
    repeat (n) begin
      bit_error <= 1'b1;
      @(posedge pclk);
      bit_error <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // ******************
  // Sequence
  // ******************
  initial begin
    tick(12);
    presetn <= 1'b1;
    tick(1);
    rd(ADDR_IRQ_ENABLE, 32'h0);
    rd(ADDR_COUNT_LOW, 32'h0);
    rd(ADDR_COUNT_HIGH, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    rd(16'h0FFC, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
    pattern_unlocked <= 1'b1;
    tick(4);
    cmp({31'h0, sync_live}, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    rd(ADDR_STATUS_LATCHED, 32'h1);
    rd(ADDR_LIVE_STATUS, 32'h1);
    apb(1'b1, ADDR_CONTROL, 32'h2);
    tick(3);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_STATUS_LATCHED, 32'h1);
    rd(ADDR_STATUS_LATCHED, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    errs(3);
    tick(3);
    rd(ADDR_STATUS_LATCHED, 32'h4);
    cmp({31'h0, irq}, 32'h1);
    cmp({31'h0, nz_live}, 32'h0);
    apb(1'b1, ADDR_STATUS_LATCHED, 32'hF);
    pattern_unlocked <= 1'b0;
    tick(3);
    cmp({31'h0, sync_live}, 32'h0);
    errs(5);
    tick(3);
    cmp({31'h0, nz_live}, 32'h1);
    rd(ADDR_COUNT_LOW, 32'h0);
    rd(ADDR_STATUS_LATCHED, 32'h7);
    apb(1'b1, ADDR_STATUS_LATCHED, 32'hF);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h8);
    apb(1'b1, ADDR_CONTROL, 32'h3);
    tick(4);
    rd(ADDR_COUNT_LOW, 32'h5);
    rd(ADDR_COUNT_HIGH, 32'h0);
    rd(ADDR_STATUS_LATCHED, 32'h8);
    rd(ADDR_LIVE_STATUS, 32'h8);
    cmp({31'h0, upd_live}, 32'h1);
    cmp({31'h0, nz_live}, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h0);
    tick(3);
    rd(ADDR_LIVE_STATUS, 32'h0);
    cmp({31'h0, upd_live}, 32'h0);
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
    tick(3);
    cmp({31'h0, irq}, 32'h0);
    bit_error <= 1'b1;
    tick(65537);
    bit_error <= 1'b0;
    tick(1);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    tick(3);
    rd(ADDR_COUNT_LOW, 32'h1);
    rd(ADDR_COUNT_HIGH, 32'h1);
    cmp({31'h0, upd_live}, 32'h1);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'hF);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(1);
    rd(ADDR_IRQ_ENABLE, 32'h0);
    rd(ADDR_COUNT_LOW, 32'h0);
    rd(ADDR_COUNT_HIGH, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    cmp({31'h0, upd_live}, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
